// ---- bench/smo_supply_monitor_chk.sv ----
// assertion checker for the supply monitor and option word block
`timescale 1ns/1ps
`default_nettype none
module smo_supply_monitor_chk
  import smo_pkg::*;
#(
  parameter smo_option_s OPTION_WORD = SMO_OPTION_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cmp_above_fall,
  input wire logic cmp_above_rise,
  input wire logic stop_req,
  input wire logic ext_read_req,
  input wire logic monitor_reset,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  input wire logic monitor_power,
  input wire logic illegal_opcode,
  input wire logic stop_mode,
  input wire logic wd_enable,
  input wire logic ext_read_grant
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // run length of low raw comparator samples, saturating
  logic [4:0] low_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      low_q <= 5'h00;
    end else if (cmp_above_fall) begin
      low_q <= 5'h00;
    end else if (low_q != 5'h1f) begin
      low_q <= low_q + 5'h01;
    end
  end
  // ==========================================================
  // reset path
  a_pin_follows_reset: assert property (
    rst_pin_oe == monitor_reset && !rst_pin_o)
    else $error("reset pin differs from monitor reset");
  a_trip_filtered: assert property (
    $rose(monitor_reset) |-> low_q >= 5'h09)
    else $error("monitor reset before nine low cycles");
  a_trip_in_time: assert property (
    low_q == 5'h0e && !stop_mode && OPTION_WORD.monitor_reset_enable &&
    OPTION_WORD.monitor_power_enable |-> monitor_reset)
    else $error("monitor reset missing after long low run");
  a_polled_only: assert property (
    !OPTION_WORD.monitor_reset_enable |-> !monitor_reset)
    else $error("monitor reset with reset option off");
  a_hold_low: assert property (
    (monitor_reset && !cmp_above_rise) [*5] |=> monitor_reset)
    else $error("monitor reset dropped below rising level");
  a_release_rise: assert property (
    (cmp_above_rise && cmp_above_fall) [*5] |=> !monitor_reset)
    else $error("monitor reset held above rising level");
  // ==========================================================
  // option word effects
  a_option_read: assert property (
    $past(reg_rd) && $past(reg_addr) == SMO_OFS_OPTION |->
    reg_rdata == OPTION_WORD)
    else $error("option word read wrong");
  a_watchdog_option: assert property (
    $past(resetn) |-> wd_enable == !OPTION_WORD.watchdog_disable)
    else $error("watchdog enable wrong");
  a_power_option: assert property (
    $past(resetn) && !stop_mode && !$past(stop_mode) &&
    !$past(stop_mode, 2) |->
    monitor_power == OPTION_WORD.monitor_power_enable)
    else $error("monitor power wrong in run");
  a_stop_entry: assert property (
    stop_req && !stop_mode && !monitor_reset |=>
    stop_mode == OPTION_WORD.stop_enable &&
    illegal_opcode == !OPTION_WORD.stop_enable)
    else $error("stop request handled wrongly");
  a_read_guard: assert property (
    $past(resetn) |->
    ext_read_grant == ($past(ext_read_req) && !OPTION_WORD.code_protection))
    else $error("external read grant wrong");
endmodule // smo_supply_monitor_chk
bind smo_supply_monitor smo_supply_monitor_chk #(.OPTION_WORD(OPTION_WORD))
  i_smo_supply_monitor_chk (.clk, .resetn, .reg_addr, .reg_rd, .reg_rdata,
  .cmp_above_fall, .cmp_above_rise, .stop_req, .ext_read_req, .monitor_reset,
  .rst_pin_o, .rst_pin_oe, .monitor_power, .illegal_opcode, .stop_mode,
  .wd_enable, .ext_read_grant);
`default_nettype wire

// ---- bench/smo_supply_monitor_test.sv ----
// self-checking testbench for the supply monitor and option word block
`timescale 1ns/1ps
`default_nettype none
module smo_supply_monitor_test
  import smo_pkg::*;
();
  localparam int WD_LONG = 40; // shortened watchdog count
  localparam int REC_LONG = 64; // shortened stop recovery count
  localparam int OSC = 4; // core cycles per oscillator period
  localparam smo_option_s OPT = SMO_OPTION_DEF;
  // second option set: resets and stop off, guards and short timings on
  localparam smo_option_s OPT_ALT = 8'hdd;
  logic alt_monitor_reset, alt_illegal, alt_wd_enable, alt_grant;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cmp_above_fall = 1'b1, cmp_above_rise = 1'b1, stop_req = 1'b0;
  logic wake_req = 1'b0, wd_service = 1'b0, ext_read_req = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0] osc_q = 2'h0; // divider for the oscillator clock
  logic irq, monitor_reset, rst_pin_o, rst_pin_oe, monitor_power;
  logic illegal_opcode, stop_mode, stop_exit, wd_enable, wd_timeout;
  logic ext_read_grant;
  int fails = 0, samples_checked = 0;
  always #5 clk = ~clk;
  // oscillator is slower than the core so ticks stay countable
  always @(posedge clk) osc_q <= osc_q + 2'h1;
  smo_supply_monitor #(.WD_SHORT(20), .WD_LONG(WD_LONG), .REC_LONG(REC_LONG))
    i_smo_supply_monitor (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .cmp_above_fall(cmp_above_fall),
    .cmp_above_rise(cmp_above_rise), .osc_clk(osc_q[1]), .stop_req(stop_req),
    .wake_req(wake_req), .wd_service(wd_service),
    .ext_read_req(ext_read_req), .monitor_reset(monitor_reset),
    .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe),
    .monitor_power(monitor_power), .illegal_opcode(illegal_opcode),
    .stop_mode(stop_mode), .stop_exit(stop_exit), .wd_enable(wd_enable),
    .wd_timeout(wd_timeout), .ext_read_grant(ext_read_grant));
  // same stimulus into a copy with the other option set, so the checker
  // also sees polled-only, illegal stop and the guarded paths
  smo_supply_monitor #(.OPTION_WORD(OPT_ALT))
    i_smo_supply_monitor_alt (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(), .irq(), .cmp_above_fall(cmp_above_fall),
    .cmp_above_rise(cmp_above_rise), .osc_clk(osc_q[1]), .stop_req(stop_req),
    .wake_req(wake_req), .wd_service(wd_service),
    .ext_read_req(ext_read_req), .monitor_reset(alt_monitor_reset),
    .rst_pin_o(), .rst_pin_oe(), .monitor_power(),
    .illegal_opcode(alt_illegal), .stop_mode(), .stop_exit(),
    .wd_enable(alt_wd_enable), .wd_timeout(),
    .ext_read_grant(alt_grant));
  // ==========================================================
  // helpers: the bench rests at falling edges between actions
  task automatic chk_val(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // cycle counts are judged with room for synchroniser slack
  task automatic chk_cnt(input string n, input int e, g);
    samples_checked++;
    if (g < e - 12 || g > e + 12) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk) reg_wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk) reg_rd <= 1'b0;
    @(negedge clk) d = reg_rdata;
  endtask
  // waits for a one-cycle pulse, bounded so a silent design cannot hang
  task automatic measure(input bit wd, output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(wd ? wd_timeout : stop_exit) && n < 2000);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [7:0] d;
    rd(SMO_OFS_STATUS, d);
    chk_val("status", SMO_RST_BYTE, d);
    wr(SMO_OFS_OPTION, 8'hff);
    rd(SMO_OFS_OPTION, d);
    chk_val("option", OPT, d);
    rd(SMO_OFS_EVENT, d);
    chk_val("events", 8'h00, d);
    rd(8'h04, d);
    chk_val("unmapped", 8'h00, d);
    chk_val("power", OPT.monitor_power_enable, monitor_power);
    @(posedge clk) ext_read_req <= 1'b1;
    cyc(3);
    chk_val("grant", !OPT.code_protection, ext_read_grant);
    chk_val("alt grant", !OPT_ALT.code_protection, alt_grant);
    @(posedge clk) ext_read_req <= 1'b0;
    cyc(2);
    chk_val("grant off", 8'h00, ext_read_grant);
    $display("test regs done");
  endtask
  task automatic t_wd();
    logic [7:0] d;
    int n;
    chk_val("wd enable", !OPT.watchdog_disable, wd_enable);
    chk_val("alt wd enable", !OPT_ALT.watchdog_disable, alt_wd_enable);
    @(posedge clk) wd_service <= 1'b1;
    @(posedge clk) wd_service <= 1'b0;
    measure(1'b1, n);
    chk_cnt("watchdog", WD_LONG * OSC, n);
    rd(SMO_OFS_EVENT, d);
    chk_val("wd event", 1'b1, d[SMO_EV_WDOG]);
    $display("test watchdog done");
  endtask
  // low runs one cycle short of the filter must never trip
  task automatic t_glitch();
    repeat (5) begin
      @(posedge clk) cmp_above_fall <= 1'b0;
      repeat (8) @(posedge clk);
      cmp_above_fall <= 1'b1;
      repeat (2) @(posedge clk);
    end
    cyc(4);
    chk_val("glitch", 1'b0, monitor_reset);
    $display("test glitch done");
  endtask
  task automatic t_flag();
    logic [7:0] d;
    @(posedge clk);
    cmp_above_fall <= 1'b0;
    cmp_above_rise <= 1'b0;
    cyc(28 * OSC);
    rd(SMO_OFS_STATUS, d);
    chk_val("flag early", 1'b0, d[SMO_FLAG_BIT]);
    cyc(16 * OSC);
    rd(SMO_OFS_STATUS, d);
    chk_val("flag late", 1'b1, d[SMO_FLAG_BIT]);
    chk_val("mon reset", 1'b1, monitor_reset);
    chk_val("reset pin", 1'b1, rst_pin_oe);
    chk_val("alt no reset", 8'h00, alt_monitor_reset);
    chk_val("no irq", 1'b0, irq);
    @(posedge clk) cmp_above_fall <= 1'b1;
    cyc(20);
    rd(SMO_OFS_STATUS, d);
    chk_val("flag held", 1'b1, d[SMO_FLAG_BIT]);
    chk_val("reset held", 1'b1, monitor_reset);
    @(posedge clk) cmp_above_rise <= 1'b1;
    cyc(6);
    chk_val("reset freed", 1'b0, monitor_reset);
    rd(SMO_OFS_STATUS, d);
    chk_val("flag clear", 1'b0, d[SMO_FLAG_BIT]);
    $display("test flag done");
  endtask
  task automatic t_stop();
    logic [7:0] d;
    int n;
    @(posedge clk) stop_req <= 1'b1;
    @(posedge clk) stop_req <= 1'b0;
    cyc(1);
    chk_val("alt illegal", !OPT_ALT.stop_enable, alt_illegal);
    cyc(1);
    chk_val("stop mode", OPT.stop_enable, stop_mode);
    chk_val("stop power", OPT.monitor_in_stop_enable, monitor_power);
    @(posedge clk) cmp_above_fall <= 1'b0;
    cyc(20);
    chk_val("stop reset", 1'b0, monitor_reset);
    @(posedge clk) cmp_above_fall <= 1'b1;
    cyc(4);
    @(posedge clk) wake_req <= 1'b1;
    @(posedge clk) wake_req <= 1'b0;
    measure(1'b0, n);
    chk_cnt("recovery", REC_LONG * OSC, n);
    wr(SMO_OFS_MASK, 8'h02);
    cyc(2);
    chk_val("irq on", 1'b1, irq);
    wr(SMO_OFS_EVENT, 8'h02);
    cyc(2);
    chk_val("irq off", 1'b0, irq);
    rd(SMO_OFS_MASK, d);
    chk_val("mask", 8'h02, d);
    $display("test stop done");
  endtask
  // ==========================================================
  // sequence, hang guard and verdict
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    cyc(2);
    t_regs();
    t_wd();
    t_glitch();
    t_flag();
    t_stop();
    complete_run();
  end
  initial begin
    #100000;
    fails++;
    complete_run();
  end
endmodule // smo_supply_monitor_test
`default_nettype wire

// ---- rtl/smo_pkg.sv ----
// constants and types shared by the supply monitor and option word block
`default_nettype none
package smo_pkg;

  // ==========================================================
  // register map (byte offsets on the plain register port)
  localparam logic [7:0] SMO_OFS_STATUS = 8'h00;
  localparam logic [7:0] SMO_OFS_OPTION = 8'h01;
  localparam logic [7:0] SMO_OFS_EVENT = 8'h02;
  localparam logic [7:0] SMO_OFS_MASK = 8'h03;

  // ==========================================================
  // field positions
  localparam int SMO_FLAG_BIT = 7;   // supply_low_flag in status
  localparam int SMO_EV_ILLEGAL = 0; // stop taken as illegal opcode
  localparam int SMO_EV_RECOVER = 1; // stop recovery finished
  localparam int SMO_EV_WDOG = 2;    // watchdog timeout
  localparam int SMO_EV_W = 3;       // number of event bits

  // ==========================================================
  // reset values
  localparam logic [7:0] SMO_RST_BYTE = 8'h00;
  localparam logic [SMO_EV_W-1:0] SMO_RST_EV = 3'h0;

  // ==========================================================
  // timing, in cycles of the named clock
  localparam int SMO_FILT_CPU = 9;      // cpu cycles at or below trip
  localparam int SMO_RISE_CPU = 1;      // cpu cycles above rising level
  localparam int SMO_FLAG_OSC = 36;     // inside the 32..40 window
  localparam int SMO_REC_SHORT = 32;    // short stop recovery
  localparam int SMO_REC_LONG = 4096;   // long stop recovery
  localparam int SMO_WD_SHORT = 8176;   // watchdog short timeout
  localparam int SMO_WD_LONG = 262128;  // watchdog long timeout
  localparam int SMO_CLK_MHZ = 100;     // core clock rate

  // ==========================================================
  // factory option word, fixed at manufacture
  typedef struct packed {
    logic monitor_in_stop_enable; // bit 7
    logic code_protection;        // bit 6
    logic monitor_reset_enable;   // bit 5
    logic monitor_power_enable;   // bit 4
    logic short_recovery_option;  // bit 3
    logic watchdog_period_select; // bit 2
    logic stop_enable;            // bit 1
    logic watchdog_disable;       // bit 0
  } smo_option_s;

  // arbitrary neutral default: monitor powered with resets enabled
  localparam smo_option_s SMO_OPTION_DEF = 8'h32;

  // stop mode sequencing
  typedef enum logic [1:0] {
    SMO_RUN,
    SMO_STOP,
    SMO_RECOVER
  } smo_stop_e;

endpackage

`default_nettype wire

// ---- rtl/smo_supply_monitor.sv ----
// supply monitor filtering, fixed option word and stop/watchdog control
// ==========================================================
// Notes on behaviour
// - monitor powered only when power option set
// - reset after nine consecutive low cpu cycles
// - hold reset until above rising level once
// - monitor reset also pulls reset pin low
// - flag set after 36 low oscillator cycles
// - flag read-only, reset-cleared, clear above rising
// - monitor never raises an interrupt request
// - reset option off means flag polling only
// - monitor stays active and resets in wait
// - stop-enabled monitor trips reset without filter
// - monitor off in stop without stop enable
// - stop recovery 32 or 4096 oscillator cycles
// - watchdog timeout 8176 or 262128 oscillator cycles
// - stop disabled means illegal opcode event
// - watchdog disable option turns watchdog off
// - code protection blocks external memory reads
// - option word fixed, readable, never writable
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module smo_supply_monitor
  import smo_pkg::*;
#(
  parameter smo_option_s OPTION_WORD = SMO_OPTION_DEF,
  parameter int WD_SHORT = SMO_WD_SHORT,
  parameter int WD_LONG = SMO_WD_LONG,
  parameter int REC_LONG = SMO_REC_LONG
) (
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  // analogue comparator outputs, asynchronous
  input wire logic cmp_above_fall,
  input wire logic cmp_above_rise,
  // oscillator clock, sampled as a plain input
  input wire logic osc_clk,
  // cpu side requests, same clock
  input wire logic stop_req,
  input wire logic wake_req,
  input wire logic wd_service,
  input wire logic ext_read_req,
  // results
  output logic monitor_reset,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic monitor_power,
  output logic illegal_opcode,
  output logic stop_mode,
  output logic stop_exit,
  output logic wd_enable,
  output logic wd_timeout,
  output logic ext_read_grant
);

  // ==========================================================
  // derived counts
  localparam int FILT_W = $clog2(SMO_FILT_CPU + 1);
  localparam int FLAG_W = $clog2(SMO_FLAG_OSC + 1);
  localparam int REC_W = $clog2(REC_LONG + 1);
  localparam int WD_W = $clog2(WD_LONG + 1);
  localparam logic [FILT_W-1:0] FILT_N = FILT_W'(SMO_FILT_CPU);
  localparam logic [FLAG_W-1:0] FLAG_N = FLAG_W'(SMO_FLAG_OSC);
  localparam logic [REC_W-1:0] REC_S = REC_W'(SMO_REC_SHORT);
  localparam logic [REC_W-1:0] REC_L = REC_W'(REC_LONG);
  localparam logic [WD_W-1:0] WD_S = WD_W'(WD_SHORT);
  localparam logic [WD_W-1:0] WD_L = WD_W'(WD_LONG);

  // option word is a constant: no write path exists anywhere
  localparam smo_option_s OPT = OPTION_WORD;

  // ==========================================================
  // synchronisers, first stage read only by the second
  logic fall_s1_q, fall_s2_q; // above falling trip
  logic rise_s1_q, rise_s2_q; // above rising trip
  logic osc_s1_q, osc_s2_q, osc_s3_q; // oscillator sample
  logic osc_tick; // one pulse per oscillator rising edge

  // two flops on every asynchronous input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fall_s1_q <= 1'b1;
      fall_s2_q <= 1'b1;
      rise_s1_q <= 1'b1;
      rise_s2_q <= 1'b1;
    end else begin
      fall_s1_q <= cmp_above_fall;
      fall_s2_q <= fall_s1_q;
      rise_s1_q <= cmp_above_rise;
      rise_s2_q <= rise_s1_q;
    end
  end

  // oscillator edge found on the second and third stage only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_clk;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
    end
  end

  assign osc_tick = osc_s2_q & ~osc_s3_q;

  // ==========================================================
  // stop state and monitor activity
  smo_stop_e stop_q, stop_d;
  logic [REC_W-1:0] rec_q; // recovery count of oscillator ticks
  logic active; // monitor powered and watching
  logic low; // synchronised supply at or below falling trip

  // monitor stays on in run and wait; stop needs its own option
  assign active = OPT.monitor_power_enable &
    ((stop_q == SMO_RUN) | OPT.monitor_in_stop_enable);
  assign low = ~fall_s2_q;

  // ==========================================================
  // cpu cycle filter on the reset path
  logic [FILT_W-1:0] filt_q; // consecutive low cpu cycles
  logic trip; // reset condition this cycle
  logic mon_rst_q; // monitor reset held

  // count low cycles, saturate, restart on any high sample
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      filt_q <= '0;
    end else if (!low || !active) begin
      filt_q <= '0;
    end else if (filt_q != FILT_N) begin
      filt_q <= filt_q + FILT_W'(1);
    end
  end

  // outside stop the filter decides; in stop the clocks of the cpu
  // are gone, so a synchronised low alone trips the reset
  always_comb begin
    trip = 1'b0;
    if (active && OPT.monitor_reset_enable) begin
      if (stop_q != SMO_RUN) begin
        trip = low;
      end else begin
        trip = (filt_q == FILT_N);
      end
    end
  end

  // held reset; one cycle above the rising level ends it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mon_rst_q <= 1'b0;
    end else if (trip) begin
      mon_rst_q <= 1'b1;
    end else if (rise_s2_q) begin
      mon_rst_q <= 1'b0;
    end
  end

  // reset outputs, the pin is open drain and only ever pulls low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monitor_reset <= 1'b0;
      rst_pin_o <= 1'b0;
      rst_pin_oe <= 1'b0;
    end else begin
      monitor_reset <= mon_rst_q | trip;
      rst_pin_o <= 1'b0;
      rst_pin_oe <= mon_rst_q | trip;
    end
  end

  // ==========================================================
  // supply-low flag, counted in oscillator cycles
  logic [FLAG_W-1:0] flag_cnt_q; // oscillator ticks spent low
  logic flag_q; // status flag, no software write

  // tick counter restarts as soon as the supply is back up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_cnt_q <= '0;
    end else if (!low || !active) begin
      flag_cnt_q <= '0;
    end else if (osc_tick && flag_cnt_q != FLAG_N) begin
      flag_cnt_q <= flag_cnt_q + FLAG_W'(1);
    end
  end

  // between the two trip levels the flag keeps its value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 1'b0;
    end else if (rise_s2_q) begin
      flag_q <= 1'b0;
    end else if (flag_cnt_q == FLAG_N) begin
      flag_q <= 1'b1;
    end
  end

  // ==========================================================
  // stop sequencing
  logic rec_done; // recovery count reached
  logic [REC_W-1:0] rec_target;

  // short recovery is unsafe with a crystal that has not settled
  assign rec_target = OPT.short_recovery_option ? REC_S : REC_L;
  assign rec_done = (rec_q == rec_target);

  always_comb begin
    stop_d = stop_q;
    case (stop_q)
      SMO_RUN: begin
        if (stop_req && OPT.stop_enable) begin
          stop_d = SMO_STOP;
        end
      end
      SMO_STOP: begin
        if (wake_req) begin
          stop_d = SMO_RECOVER;
        end
      end
      SMO_RECOVER: begin
        if (rec_done) begin
          stop_d = SMO_RUN;
        end
      end
      default: begin
        stop_d = SMO_RUN;
      end
    endcase
    // a monitor reset pulls the device out of stop at once
    if (trip || mon_rst_q) begin
      stop_d = SMO_RUN;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stop_q <= SMO_RUN;
    end else begin
      stop_q <= stop_d;
    end
  end

  // recovery counter runs only while recovering
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rec_q <= '0;
    end else if (stop_q != SMO_RECOVER) begin
      rec_q <= '0;
    end else if (osc_tick && !rec_done) begin
      rec_q <= rec_q + REC_W'(1);
    end
  end

  // stop status and single-cycle pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stop_mode <= 1'b0;
      stop_exit <= 1'b0;
      illegal_opcode <= 1'b0;
      monitor_power <= 1'b0;
    end else begin
      stop_mode <= (stop_d != SMO_RUN);
      stop_exit <= (stop_q == SMO_RECOVER) && rec_done &&
        !trip && !mon_rst_q;
      illegal_opcode <= (stop_q == SMO_RUN) && stop_req &&
        !OPT.stop_enable;
      monitor_power <= active;
    end
  end

  // ==========================================================
  // watchdog period and enable
  logic [WD_W-1:0] wd_q; // oscillator ticks since service
  logic [WD_W-1:0] wd_target;
  logic wd_on;

  assign wd_on = ~OPT.watchdog_disable;
  assign wd_target = OPT.watchdog_period_select ? WD_S : WD_L;

  // the watchdog sleeps in stop so that recovery cannot bite
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wd_q <= '0;
    end else if (!wd_on || wd_service || stop_q != SMO_RUN) begin
      wd_q <= '0;
    end else if (wd_q == wd_target) begin
      wd_q <= '0;
    end else if (osc_tick) begin
      wd_q <= wd_q + WD_W'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wd_enable <= 1'b0;
      wd_timeout <= 1'b0;
    end else begin
      wd_enable <= wd_on;
      wd_timeout <= wd_on && !wd_service &&
        (stop_q == SMO_RUN) && (wd_q == wd_target);
    end
  end

  // ==========================================================
  // code protection on external program memory reads
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_read_grant <= 1'b0;
    end else begin
      ext_read_grant <= ext_read_req && !OPT.code_protection;
    end
  end

  // ==========================================================
  // event status and mask; the monitor itself feeds no event
  logic [SMO_EV_W-1:0] ev_q; // sticky events, write one to clear
  logic [SMO_EV_W-1:0] mask_q; // interrupt enables
  logic [SMO_EV_W-1:0] ev_set;
  logic [SMO_EV_W-1:0] ev_clr;
  logic wr_event;

  assign wr_event = reg_wr && (reg_addr == SMO_OFS_EVENT);
  assign ev_clr = wr_event ? reg_wdata[SMO_EV_W-1:0] : '0;

  always_comb begin
    ev_set = '0;
    ev_set[SMO_EV_ILLEGAL] = illegal_opcode;
    ev_set[SMO_EV_RECOVER] = stop_exit;
    ev_set[SMO_EV_WDOG] = wd_timeout;
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ev_q <= SMO_RST_EV;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_q <= SMO_RST_EV;
    end else if (reg_wr && reg_addr == SMO_OFS_MASK) begin
      mask_q <= reg_wdata[SMO_EV_W-1:0];
    end
  end

  // level interrupt from the stored bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((ev_q & ~ev_clr) | ev_set) & mask_q);
    end
  end

  // ==========================================================
  // read path: data stand one cycle after the strobe, else zero
  logic [7:0] rd_d;

  always_comb begin
    rd_d = SMO_RST_BYTE;
    case (reg_addr)
      SMO_OFS_STATUS: rd_d[SMO_FLAG_BIT] = flag_q;
      SMO_OFS_OPTION: rd_d = OPT;
      SMO_OFS_EVENT: rd_d[SMO_EV_W-1:0] = ev_q;
      SMO_OFS_MASK: rd_d[SMO_EV_W-1:0] = mask_q;
      default: rd_d = SMO_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= SMO_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end else begin
      reg_rdata <= SMO_RST_BYTE;
    end
  end

endmodule // smo_supply_monitor

`default_nettype wire
